// file: logic/sec_device.sv
`timescale 1ns/1ps
module sec_device #(
  parameter int PROG_CYCLES = sec_pkg::PROG_CYCLES
) (
  input  wire logic  linkClk,
  input  wire logic  clk,
  input  wire logic  reset_n,
  sec_link_if.device bus,
  output logic       progBusy,
  output logic       writeEnabled
);
  localparam int FW  = sec_pkg::FRAME_W;
  localparam int CW  = sec_pkg::CNT_W;
  localparam int PCW = $clog2(PROG_CYCLES + 1);
  // clk domain: the internal oscillator that times programming
  logic [7:0]    memBytes [sec_pkg::NUM_BYTES];
  logic [2:0]    csPipe, orgPipe;
  logic          csStable, orgStable, csPrev, csFall;
  logic [3:0]    lvlMeta, lvlSync;
  logic          doneSync, startSync, readSync, bitSync, doneUsed;
  logic [PCW-1:0] progCnt;
  logic          progEnd, ready, exWide;
  logic [1:0]    exOp, exExt;
  logic [6:0]    exAddr;
  logic [15:0]   exData;

  // link domain
  logic          frameRst_n, wideLink, started, cmdDone, reading, readBit;
  logic [1:0]    wideSync, rxOp, rxExt, cmdOp, cmdExt;
  logic [CW-1:0] bitCnt, addrEnd, dataEnd;
  logic [FW-1:0] inShift, nextShift;
  logic [6:0]    rxAddr, cmdAddr, rdAddr;
  logic [15:0]   rxData, cmdData, outShift;
  logic [3:0]    outCnt, unitLast;

  // one read unit, left aligned; word w is bytes 2w (high) and 2w+1 (low)
  function automatic logic [15:0] unit_at(input logic [6:0] a, input logic w);
    return w ? {memBytes[{a[5:0], 1'h0}], memBytes[{a[5:0], 1'h1}]} : {memBytes[a], 8'h00};
  endfunction
  // next read location, wrapping within the selected organisation
  function automatic logic [6:0] step(input logic [6:0] a, input logic w);
    return w ? {1'h0, a[5:0] + 6'h01} : a + 7'h01;
  endfunction

  // link domain: a frame ends with cs low, which may come with no further clock edge
  assign frameRst_n = reset_n & bus.cs;

  // organisation seen by the decoder; the strap is static in use
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) wideSync <= 2'h3;
    else          wideSync <= {wideSync[0], orgStable};
  end
  assign wideLink = wideSync[1];

  assign addrEnd  = wideLink ? CW'(sec_pkg::ADDR_END_WORD) : CW'(sec_pkg::ADDR_END_BYTE);
  assign dataEnd  = wideLink ? CW'(sec_pkg::DATA_END_WORD) : CW'(sec_pkg::DATA_END_BYTE);
  assign unitLast = wideLink ? 4'(sec_pkg::DATA_W - 1) : 4'(sec_pkg::BYTE_W - 1);
  assign nextShift = {inShift[FW-2:0], bus.di};

  // field extraction as the current bit lands
  always_comb begin
    if (wideLink) begin
      rxOp   = nextShift[sec_pkg::WORD_ADDR_W +: sec_pkg::OP_W];
      rxAddr = {1'h0, nextShift[sec_pkg::WORD_ADDR_W-1:0]};
      rxExt  = nextShift[sec_pkg::WORD_ADDR_W-2 +: 2];
      rxData = nextShift[sec_pkg::DATA_W-1:0];
    end else begin
      rxOp   = nextShift[sec_pkg::ADDR_W +: sec_pkg::OP_W];
      rxAddr = nextShift[sec_pkg::ADDR_W-1:0];
      rxExt  = nextShift[sec_pkg::ADDR_W-2 +: 2];
      rxData = {8'h00, nextShift[sec_pkg::BYTE_W-1:0]};
    end
  end

  // start-bit hunt and bit counting; leading zeros are skipped
  always_ff @(posedge linkClk or negedge frameRst_n) begin
    if (!frameRst_n) begin
      started <= 1'h0;
      bitCnt  <= '0;
      inShift <= '0;
    end else if (!started) begin
      started <= bus.di;
    end else begin
      inShift <= nextShift;
      if (bitCnt != '1) bitCnt <= bitCnt + CW'(1);
    end
  end

  // decoded command survives cs low so the clk domain can launch it
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      cmdOp   <= sec_pkg::OP_READ;
      cmdExt  <= sec_pkg::EXT_LOCK;
      cmdAddr <= 7'h00;
      cmdData <= 16'h0000;
      cmdDone <= 1'h0;
    end else if (bus.cs) begin
      if (!started) begin
        if (bus.di) cmdDone <= 1'h0;
      end else if (bitCnt == addrEnd) begin
        cmdOp   <= rxOp;
        cmdExt  <= rxExt;
        cmdAddr <= rxAddr;
        cmdDone <= rxOp == sec_pkg::OP_ERASE ||
                   (rxOp == sec_pkg::OP_EXT && rxExt != sec_pkg::EXT_FILL);
      end else if (bitCnt == dataEnd && (cmdOp == sec_pkg::OP_WRITE ||
                   (cmdOp == sec_pkg::OP_EXT && cmdExt == sec_pkg::EXT_FILL))) begin
        cmdData <= rxData;
        cmdDone <= 1'h1;
      end else begin
        cmdDone <= 1'h0; // a stray edge after the last bit voids the command
      end
    end
  end

  // read path: dummy zero, then units back to back until cs falls
  always_ff @(posedge linkClk or negedge frameRst_n) begin
    if (!frameRst_n) begin
      reading  <= 1'h0;
      readBit  <= 1'h0;
      outShift <= 16'h0000;
      outCnt   <= 4'h0;
      rdAddr   <= 7'h00;
    end else if (started && !reading && bitCnt == addrEnd && rxOp == sec_pkg::OP_READ) begin
      reading  <= 1'h1;
      readBit  <= 1'h0;
      rdAddr   <= rxAddr;
      outShift <= unit_at(rxAddr, wideLink);
      outCnt   <= 4'h0;
    end else if (reading) begin
      readBit <= outShift[15];
      if (outCnt == unitLast) begin
        rdAddr   <= step(rdAddr, wideLink);
        outShift <= unit_at(step(rdAddr, wideLink), wideLink);
        outCnt   <= 4'h0;
      end else begin
        outShift <= outShift << 1;
        outCnt   <= outCnt + 4'h1;
      end
    end
  end

  // clk domain: cs and strap pins, a change counts once stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csPipe    <= 3'h0;
      orgPipe   <= 3'h7;
      csStable  <= 1'h0;
      orgStable <= 1'h1;
      csPrev    <= 1'h0;
    end else begin
      csPipe  <= {csPipe[1:0], bus.cs};
      orgPipe <= {orgPipe[1:0], bus.orgWide};
      if (csPipe[1] == csPipe[2])   csStable  <= csPipe[2];
      if (orgPipe[1] == orgPipe[2]) orgStable <= orgPipe[2];
      csPrev <= csStable;
    end
  end
  assign csFall = csPrev & ~csStable;

  // one launch per decoded frame; the bare cs pulse of a status poll must not repeat it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)       doneUsed <= 1'h0;
    else if (!doneSync) doneUsed <= 1'h0;
    else if (csFall)    doneUsed <= 1'h1;
  end

  // levels from the link domain, two flip-flops each
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lvlMeta <= 4'h0;
      lvlSync <= 4'h0;
    end else begin
      lvlMeta <= {cmdDone, started, reading, readBit};
      lvlSync <= lvlMeta;
    end
  end
  assign {doneSync, startSync, readSync, bitSync} = lvlSync;

  // launch at cs fall; cmd fields are steady once done has crossed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      writeEnabled <= 1'h0;
      progBusy     <= 1'h0;
      progCnt      <= '0;
      exOp         <= sec_pkg::OP_READ;
      exExt        <= sec_pkg::EXT_LOCK;
      exAddr       <= 7'h00;
      exData       <= 16'h0000;
      exWide       <= 1'h1;
    end else if (progBusy) begin
      // runs on clk alone, so a stopped or running link clock changes nothing
      if (progCnt == '0) progBusy <= 1'h0;
      else               progCnt  <= progCnt - PCW'(1);
    end else if (csFall && doneSync && !doneUsed) begin
      if (cmdOp == sec_pkg::OP_EXT && cmdExt == sec_pkg::EXT_UNLOCK) begin
        writeEnabled <= 1'h1;
      end else if (cmdOp == sec_pkg::OP_EXT && cmdExt == sec_pkg::EXT_LOCK) begin
        writeEnabled <= 1'h0;
      end else if (writeEnabled) begin
        progBusy <= 1'h1;
        progCnt  <= PCW'(PROG_CYCLES - 1);
        exOp     <= cmdOp;
        exExt    <= cmdExt;
        exAddr   <= cmdAddr;
        exData   <= cmdData;
        exWide   <= orgStable;
      end
    end
  end
  assign progEnd = progBusy && progCnt == '0;

  // array update at the end of the timed cycle; contents start erased
  for (genvar i = 0; i < sec_pkg::NUM_BYTES; i++) begin : g_byte
    localparam bit HIGH_LANE = (i % 2) == 0;
    logic       hit;
    logic [7:0] lane;
    assign hit  = exOp == sec_pkg::OP_EXT ||
                  (exWide ? exAddr[5:0] == 6'(i / 2) : exAddr == 7'(i));
    assign lane = (exWide && HIGH_LANE) ? exData[15:8] : exData[7:0];
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        memBytes[i] <= sec_pkg::ERASED_BYTE;
      end else if (progEnd && hit) begin
        if (exOp == sec_pkg::OP_ERASE || exExt == sec_pkg::EXT_CLEAR && exOp == sec_pkg::OP_EXT)
          memBytes[i] <= sec_pkg::ERASED_BYTE;
        else if (exOp == sec_pkg::OP_WRITE)
          memBytes[i] <= lane;
        else
          memBytes[i] <= memBytes[i] & lane;
      end
    end
  end

  // ready flag: end of cycle wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)                  ready <= 1'h0;
    else if (progEnd)              ready <= 1'h1;
    else if (startSync || csFall)  ready <= 1'h0;
  end

  // serial output: busy low, ready high, else read data; off with cs low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.q   <= 1'h0;
      bus.qOe <= 1'h0;
    end else begin
      bus.qOe <= csStable && (progBusy || ready || readSync);
      if (progBusy)   bus.q <= 1'h0;
      else if (ready) bus.q <= 1'h1;
      else            bus.q <= bitSync;
    end
  end
endmodule // sec_device

// file: logic/sec_pkg.sv
package sec_pkg;
  // op-codes and extended op-codes carried in the two leading address bits
  localparam int         OP_W        = 2;
  localparam logic [1:0] OP_READ     = 2'h2;
  localparam logic [1:0] OP_WRITE    = 2'h1;
  localparam logic [1:0] OP_ERASE    = 2'h3;
  localparam logic [1:0] OP_EXT      = 2'h0;
  localparam logic [1:0] EXT_UNLOCK  = 2'h3;
  localparam logic [1:0] EXT_LOCK    = 2'h0;
  localparam logic [1:0] EXT_CLEAR   = 2'h2;
  localparam logic [1:0] EXT_FILL    = 2'h1;
  // array shape
  localparam int         ADDR_W      = 7;
  localparam int         WORD_ADDR_W = 6;
  localparam int         DATA_W      = 16;
  localparam int         BYTE_W      = 8;
  localparam int         NUM_BYTES   = 128;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int         FRAME_W     = 1 + OP_W + WORD_ADDR_W + DATA_W;
  localparam int         CNT_W       = 5;
  // bit index (after the start bit) of the last address and last data bit
  localparam int ADDR_END_BYTE = OP_W + ADDR_W - 1;
  localparam int ADDR_END_WORD = OP_W + WORD_ADDR_W - 1;
  localparam int DATA_END_BYTE = ADDR_END_BYTE + BYTE_W;
  localparam int DATA_END_WORD = ADDR_END_WORD + DATA_W;
  // timing at the 40 MHz system clock
  localparam int CLK_PERIOD_NS    = 25;
  localparam int PROG_TIME_MS     = 10;
  localparam int PROG_CYCLES      = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SK_PERIOD_MIN_NS = 1000;
  localparam int SK_HALF_CYCLES   = (SK_PERIOD_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_LOW_MIN_NS    = 250;
  localparam int CS_GAP_CYCLES    = (CS_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // instructions the host end can issue
  typedef enum logic [2:0] {
    CMD_READ      = 3'h0,
    CMD_WRITE     = 3'h1,
    CMD_ERASE     = 3'h2,
    CMD_UNLOCK    = 3'h3,
    CMD_LOCK      = 3'h4,
    CMD_CLEAR_ALL = 3'h5,
    CMD_FILL_ALL  = 3'h6
  } sec_cmd_t;
endpackage

// file: logic/sec_link_if.sv
`timescale 1ns/1ps
interface sec_link_if;
  logic cs;       // chip select, high during a frame
  logic sk;       // serial clock, made by the host
  logic di;       // serial data into the memory
  logic q;        // serial data out of the memory
  logic qOe;      // memory drives q while high
  logic orgWide;  // organisation strap, high for 16-bit words
  logic qLine;    // resolved output wire, pulled high when undriven

  assign qLine = qOe ? q : 1'h1;

  modport host (output cs, output sk, output di, input qLine);
  modport device (input cs, input di, input orgWide, output q, output qOe);
endinterface

// file: logic/sec_host.sv
`timescale 1ns/1ps
module sec_host (
  input  wire logic              clk,
  input  wire logic              reset_n,
  sec_link_if.host               bus,
  input  wire logic              cmdValid,
  output logic                   cmdReady,
  input  sec_pkg::sec_cmd_t      cmdKind,
  input  wire logic [6:0]        cmdAddr,
  input  wire logic [15:0]       cmdData,
  input  wire logic [7:0]        cmdUnits,
  input  wire logic              wide,
  output logic                   rspValid,
  output logic [15:0]            rspData
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_SEND = 3'h1,
    H_READ = 3'h2,
    H_GAP  = 3'h3,
    H_POLL = 3'h4
  } sec_hstate_t;

  localparam int TW = 5;
  localparam int FW = sec_pkg::FRAME_W;

  sec_hstate_t          state;
  logic [TW-1:0]        timer;
  logic [FW-1:0]        frame;
  logic [4:0]           bitsLeft;
  logic [15:0]          rxShift;
  logic [3:0]           rxCnt;
  logic [7:0]           unitsLeft;
  logic                 isRead, isWide, dummy, pollNext;
  logic [2:0]           qPipe;
  logic                 qStable;
  logic [1:0]           op, ext;
  logic [FW-1:0]        next_frame;
  logic [4:0]           next_len;
  logic [3:0]           unitLast;

  // q from the memory: a change counts once the second and third stage agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      qPipe   <= 3'h7;
      qStable <= 1'h1;
    end else begin
      qPipe <= {qPipe[1:0], bus.qLine};
      if (qPipe[1] == qPipe[2]) qStable <= qPipe[2];
    end
  end

  // frame image, start bit in the msb
  always_comb begin
    op  = sec_pkg::OP_EXT;
    ext = sec_pkg::EXT_LOCK;
    unique case (cmdKind)
      sec_pkg::CMD_READ:      op = sec_pkg::OP_READ;
      sec_pkg::CMD_WRITE:     op = sec_pkg::OP_WRITE;
      sec_pkg::CMD_ERASE:     op = sec_pkg::OP_ERASE;
      sec_pkg::CMD_UNLOCK:    ext = sec_pkg::EXT_UNLOCK;
      sec_pkg::CMD_CLEAR_ALL: ext = sec_pkg::EXT_CLEAR;
      sec_pkg::CMD_FILL_ALL:  ext = sec_pkg::EXT_FILL;
      default:                ext = sec_pkg::EXT_LOCK;
    endcase
    if (wide) begin
      next_frame = {1'h1, op, (op == sec_pkg::OP_EXT) ? {ext, 4'h0} : cmdAddr[5:0], cmdData};
      next_len   = 5'(sec_pkg::ADDR_END_WORD + 2);
      unitLast   = 4'(sec_pkg::DATA_W - 1);
    end else begin
      next_frame = {1'h1, op, (op == sec_pkg::OP_EXT) ? {ext, 5'h00} : cmdAddr, cmdData[7:0], 7'h00};
      next_len   = 5'(sec_pkg::ADDR_END_BYTE + 2);
      unitLast   = 4'(sec_pkg::BYTE_W - 1);
    end
    if (cmdKind == sec_pkg::CMD_WRITE || cmdKind == sec_pkg::CMD_FILL_ALL)
      next_len = next_len + 5'(unitLast) + 5'h1;
  end

  // sequencer: the serial clock is a divider of clk, half a period per tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= H_IDLE; cmdReady <= 1'h0; rspValid <= 1'h0; rspData <= 16'h0000;
      bus.cs <= 1'h0; bus.sk <= 1'h0; bus.di <= 1'h0;
      timer <= '0; frame <= '0; bitsLeft <= '0; rxShift <= 16'h0000; rxCnt <= 4'h0;
      unitsLeft <= 8'h00; isRead <= 1'h0; isWide <= 1'h0; dummy <= 1'h0; pollNext <= 1'h0;
    end else begin
      rspValid <= 1'h0;
      if (timer != '0) timer <= timer - TW'(1);
      unique case (state)
        H_IDLE: begin
          cmdReady <= 1'h1;
          if (cmdValid && cmdReady) begin
            cmdReady  <= 1'h0;
            frame     <= next_frame;
            bitsLeft  <= next_len;
            isRead    <= cmdKind == sec_pkg::CMD_READ;
            isWide    <= wide;
            unitsLeft <= (cmdUnits == 8'h00) ? 8'h01 : cmdUnits;
            pollNext  <= op != sec_pkg::OP_READ && !(op == sec_pkg::OP_EXT &&
                         (ext == sec_pkg::EXT_UNLOCK || ext == sec_pkg::EXT_LOCK));
            bus.cs    <= 1'h1; // cs rises while sk is low
            bus.di    <= next_frame[FW-1];
            timer     <= TW'(sec_pkg::SK_HALF_CYCLES - 1);
            state     <= H_SEND;
          end
        end
        H_SEND: if (timer == '0) begin
          timer <= TW'(sec_pkg::SK_HALF_CYCLES - 1);
          bus.sk <= !bus.sk;
          if (!bus.sk) begin
            bitsLeft <= bitsLeft - 5'h1;
          end else if (bitsLeft == 5'h0) begin
            dummy <= 1'h1;
            rxCnt <= 4'h0;
            if (isRead) begin
              state <= H_READ;
            end else begin
              bus.cs <= 1'h0;
              timer  <= TW'(sec_pkg::CS_GAP_CYCLES - 1);
              state  <= H_GAP;
            end
          end else begin
            frame  <= frame << 1;
            bus.di <= frame[FW-2];
          end
        end
        H_READ: if (timer == '0) begin
          timer <= TW'(sec_pkg::SK_HALF_CYCLES - 1);
          bus.sk <= !bus.sk;
          if (!bus.sk) begin
            // q has been steady for half a period before this rise
            dummy <= 1'h0;
            if (!dummy) begin
              rxShift <= {rxShift[14:0], qStable};
              rxCnt   <= rxCnt + 4'h1;
              if (rxCnt == (isWide ? 4'(sec_pkg::DATA_W - 1) : 4'(sec_pkg::BYTE_W - 1))) begin
                rxCnt     <= 4'h0;
                rspValid  <= 1'h1;
                rspData   <= isWide ? {rxShift[14:0], qStable} : {8'h00, rxShift[6:0], qStable};
                unitsLeft <= unitsLeft - 8'h01;
              end
            end
          end else if (unitsLeft == 8'h00) begin
            bus.cs <= 1'h0;
            timer  <= TW'(sec_pkg::CS_GAP_CYCLES - 1);
            state  <= H_GAP;
          end
        end
        H_GAP: if (timer == '0) begin
          if (pollNext) begin
            // wait out the memory's answer latency before judging q
            pollNext <= 1'h0;
            bus.cs   <= 1'h1;
            timer    <= TW'(sec_pkg::CS_GAP_CYCLES - 1);
            state    <= H_POLL;
          end else begin
            state <= H_IDLE;
          end
        end
        H_POLL: if (timer == '0 && qStable) begin
          bus.cs <= 1'h0;
          timer  <= TW'(sec_pkg::CS_GAP_CYCLES - 1);
          state  <= H_GAP;
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule // sec_host

// file: tb/sec_link_monitor.sv
`timescale 1ns/1ps
module sec_link_monitor #(
  parameter int PROG_CYCLES = 50
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  input wire logic q,
  input wire logic qOe,
  input wire logic orgWide,
  input wire logic progBusy,
  input wire logic writeEnabled
);
  logic [31:0] busyLen;

  default clocking mck @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // length of the running programming cycle, cleared when it ends
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) busyLen <= 32'h0;
    else busyLen <= progBusy ? busyLen + 32'h1 : 32'h0;
  end

  // the output stage lags chip select by a few clk, so allow eight
  q_release_a: assert property ((!cs) [*8] |-> !qOe)
    else $error("q driven while deselected");
  busy_low_a: assert property (progBusy && $past(progBusy, 6) && cs && $past(cs, 6) |-> qOe && !q)
    else $error("busy not shown low");
  prog_len_a: assert property ($fell(progBusy) |-> busyLen >= PROG_CYCLES - 1 && busyLen <= PROG_CYCLES + 1)
    else $error("programming length wrong");
  lock_gate_a: assert property ($rose(progBusy) |-> writeEnabled)
    else $error("programming while locked");
  enable_edge_a: assert property ($changed(writeEnabled) |-> !cs)
    else $error("lock state changed inside a frame");
  ready_rise_a: assert property (cs && !sk && !progBusy && $past(progBusy) |-> ##[1:6] (qOe && q))
    else $error("ready not shown");
  ready_hold_a: assert property (cs && !sk && qOe && q && !progBusy ##1 cs && !sk |-> qOe && q)
    else $error("ready dropped early");
  q_fall_sk_a: assert property (cs && qOe && $past(qOe) && $fell(q) |-> sk)
    else $error("q changed away from clock rise");
  launch_a: assert property ($rose(progBusy) |-> !cs && !$past(cs, 2))
    else $error("programming began inside a frame");

  cover property ($rose(progBusy));
  cover property (cs && qOe && q && !progBusy);
  cover property ($fell(writeEnabled));
  cover property ($rose(progBusy) && orgWide);
  cover property (cs && di && qOe && !q && progBusy);
endmodule // sec_link_monitor

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int PROG = 50;
  logic              clk;
  logic              reset_n;
  logic              cmdValid;
  logic              cmdReady;
  sec_pkg::sec_cmd_t cmdKind;
  logic [6:0]        cmdAddr;
  logic [15:0]       cmdData;
  logic [7:0]        cmdUnits;
  logic              wide;
  logic              rspValid;
  logic [15:0]       rspData;
  logic              progBusy;
  logic              writeEnabled;
  logic [15:0]       got[$];
  int                fails;
  int                testsRun;

  sec_link_if link ();
  assign link.orgWide = wide;

  sec_host sec_host_i (.clk(clk), .reset_n(reset_n), .bus(link.host), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdUnits(cmdUnits), .wide(wide),
    .rspValid(rspValid), .rspData(rspData));
  // short programming time keeps the run brief
  sec_device #(.PROG_CYCLES(PROG)) sec_device_i (.linkClk(link.sk), .clk(clk), .reset_n(reset_n),
    .bus(link.device), .progBusy(progBusy), .writeEnabled(writeEnabled));
  sec_link_monitor #(.PROG_CYCLES(PROG)) sec_link_monitor_i (.clk(clk), .reset_n(reset_n), .cs(link.cs),
    .sk(link.sk), .di(link.di), .q(link.q), .qOe(link.qOe), .orgWide(link.orgWide), .progBusy(progBusy),
    .writeEnabled(writeEnabled));

  // 40 MHz system clock
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (fails == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // wait for the host to go idle, gathering read units on the way
  task automatic settle;
    int n;
    for (n = 0; cmdReady !== 1'h1; n++) begin
      @(posedge clk);
      #1;
      if (rspValid === 1'h1) got.push_back(rspData);
      if (n > 40000) begin
        fails++;
        report_and_stop();
      end
    end
  endtask

  task automatic issue(input sec_pkg::sec_cmd_t k, input logic [6:0] a, input logic [15:0] d, input logic [7:0] u);
    settle();
    cmdKind = k;
    cmdAddr = a;
    cmdData = d;
    cmdUnits = u;
    cmdValid = 1'h1;
    @(posedge clk);
    #1;
    cmdValid = 1'h0;
    got.delete();
    settle();
    check("busy", {15'h0000, progBusy}, 16'h0000);
  endtask

  // two units per read, so every read also streams past its first unit
  task automatic rd(input logic [6:0] a, input logic [15:0] e0, input logic [15:0] e1);
    issue(sec_pkg::CMD_READ, a, 16'h0000, 8'h02);
    check("units", 16'(got.size()), 16'h0002);
    check("unit0", got[0], e0);
    check("unit1", got[1], e1);
  endtask

  initial begin
    reset_n = 1'h0;
    cmdValid = 1'h0;
    cmdKind = sec_pkg::CMD_READ;
    cmdAddr = 7'h00;
    cmdData = 16'h0000;
    cmdUnits = 8'h00;
    wide = 1'h0;
    fails = 0;
    testsRun = 0;
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'h1;
    repeat (4) @(posedge clk);
    #1;
    check("lock", {15'h0000, writeEnabled}, 16'h0000);
    rd(7'h05, 16'h00FF, 16'h00FF);
    issue(sec_pkg::CMD_WRITE, 7'h05, 16'h00A5, 8'h01);
    rd(7'h05, 16'h00FF, 16'h00FF);
    issue(sec_pkg::CMD_UNLOCK, 7'h00, 16'h0000, 8'h01);
    check("lock", {15'h0000, writeEnabled}, 16'h0001);
    issue(sec_pkg::CMD_WRITE, 7'h05, 16'h00A5, 8'h01);
    issue(sec_pkg::CMD_WRITE, 7'h06, 16'h003C, 8'h01);
    rd(7'h05, 16'h00A5, 16'h003C);
    // a write replaces the byte, so 5A overwrites A5 with no erase before it
    issue(sec_pkg::CMD_WRITE, 7'h05, 16'h005A, 8'h01);
    issue(sec_pkg::CMD_ERASE, 7'h06, 16'h0000, 8'h01);
    rd(7'h05, 16'h005A, 16'h00FF);
    issue(sec_pkg::CMD_WRITE, 7'h7F, 16'h0012, 8'h01);
    issue(sec_pkg::CMD_WRITE, 7'h00, 16'h0034, 8'h01);
    rd(7'h7F, 16'h0012, 16'h0034);
    issue(sec_pkg::CMD_CLEAR_ALL, 7'h00, 16'h0000, 8'h01);
    rd(7'h05, 16'h00FF, 16'h00FF);
    issue(sec_pkg::CMD_FILL_ALL, 7'h00, 16'h000F, 8'h01);
    issue(sec_pkg::CMD_FILL_ALL, 7'h00, 16'h00F3, 8'h01);
    rd(7'h40, 16'h0003, 16'h0003);
    issue(sec_pkg::CMD_LOCK, 7'h00, 16'h0000, 8'h01);
    check("lock", {15'h0000, writeEnabled}, 16'h0000);
    issue(sec_pkg::CMD_ERASE, 7'h40, 16'h0000, 8'h01);
    rd(7'h40, 16'h0003, 16'h0003);
    // word organisation: word 0 pairs bytes 0 and 1
    wide = 1'h1;
    issue(sec_pkg::CMD_UNLOCK, 7'h00, 16'h0000, 8'h01);
    issue(sec_pkg::CMD_WRITE, 7'h3F, 16'h1234, 8'h01);
    rd(7'h3F, 16'h1234, 16'h0303);
    report_and_stop();
  end
endmodule // tb_top
